// [rtl/dds_pkg.sv]
// Constants and helpers shared by the synthesis core and its host
// Behaviour
// - Phase accumulates tuning word each clock
// - Zero tuning word holds present phase
// - Clear bit forces phase output zero
// - Clear bit active one, pending zero
// - Cosine mapper converts phase to amplitude
// - Amplitude samples are ten bits
// - Multiplier field in bits seven to three
// - Values four to twenty multiply reference
// - Host keeps multiplied clock within limit; dds_host sends any multiplier value unchecked
// - Host waits lock time after multiplier change; dds_host waits only after an update strobe that ends an ADDR_CTRL_TWO write
// - Other values bypass and power down
// - Select pin enables oscillator and output
// - Gate bit stops system clock only
// - Bit nine enables crystal output pin
// - Multiplier and gate bit are independent
// - System clock ratio follows mode table
// - Serial access, either bit order
// - Two-wire and three-wire serial modes
// - Resync and select pins optional
// - Resync aborts transfer in progress
// - Host drives select low to address
// - Data output used only in three-wire
`default_nettype none
package dds_pkg;
  localparam logic [4:0] ADDR_CTRL_ONE = 5'h00;
  localparam logic [4:0] ADDR_CTRL_TWO = 5'h01;
  localparam logic [4:0] ADDR_FTW = 5'h04;
  localparam int READ_FLAG_POS = 7;
  localparam int INSTR_BITS = 8;
  localparam int GATE_POS = 4;
  localparam int LSB_FIRST_POS = 8;
  localparam int THREE_WIRE_POS = 9;
  localparam int CLEAR_POS = 10;
  localparam int MULT_LSB = 3;
  localparam int MULT_W = 5;
  localparam int XTAL_OUT_POS = 9;
  localparam logic [4:0] MULT_MIN = 5'h04;
  localparam logic [4:0] MULT_MAX = 5'h14;
  localparam int ACC_W = 32;
  localparam int DAC_W = 10;
  localparam logic [31:0] CTRL_ONE_RESET = 32'h0000_0400;
  localparam logic [31:0] PEND_ONE_RESET = 32'h0000_0000;
  localparam logic [31:0] CTRL_TWO_RESET = 32'h0000_0000;
  localparam logic [31:0] FTW_RESET = 32'h0000_0000;
  localparam int CLOCK_NS = 20;
  localparam int PLL_LOCK_NS = 1000000;
  localparam int PLL_LOCK_CYCLES = (PLL_LOCK_NS + CLOCK_NS - 1) / CLOCK_NS;
  localparam int SCLK_HALF_CYCLES = 2;
  localparam logic [7:0] HOST_CMD = 8'h00;
  localparam logic [7:0] HOST_WDATA = 8'h04;
  localparam logic [7:0] HOST_RDATA = 8'h08;
  localparam logic [7:0] HOST_STATUS = 8'h0c;
  localparam logic [7:0] HOST_CONFIG = 8'h10;
  localparam int CMD_READ_POS = 7;
  localparam int CMD_UPDATE_POS = 8;
  localparam int STAT_BUSY_POS = 0;
  localparam int STAT_LOCK_POS = 1;
  localparam int CFG_LSB_POS = 0;
  localparam int CFG_THREE_POS = 1;

  // Data bits carried by each register
  function automatic logic [5:0] reg_bits(input logic [4:0] addr);
    case (addr)
      ADDR_CTRL_ONE: reg_bits = 6'h20;
      ADDR_CTRL_TWO: reg_bits = 6'h18;
      ADDR_FTW: reg_bits = 6'h20;
      default: reg_bits = 6'h08;
    endcase
  endfunction : reg_bits

  // Bit position of frame bit cnt within its field
  function automatic logic [5:0] frame_pos(input logic [5:0] cnt,
      input logic [5:0] width, input logic lsb);
    logic [5:0] d;
    d = cnt - 6'h08;
    if (cnt < 6'h08) begin
      frame_pos = lsb ? cnt : 6'h07 - cnt;
    end else begin
      frame_pos = lsb ? d : width - 6'h01 - d;
    end
  endfunction : frame_pos
endpackage : dds_pkg
`default_nettype wire

// [rtl/dds_serial_if.sv]
// Serial control link between host and synthesis core
`default_nettype none
interface dds_serial_if;
  logic sclk;
  logic cs_n;
  logic resync;
  logic io_update;
  logic host_sdio_o;
  logic host_sdio_oe;
  logic dev_sdio_o;
  logic dev_sdio_oe;
  logic sdio;
  logic serial_data_output;
  // Resolved shared data wire, pulled high when idle
  assign sdio = host_sdio_oe ? host_sdio_o :
                (dev_sdio_oe ? dev_sdio_o : 1'b1);
  modport device (input sclk, cs_n, resync, io_update, sdio,
                  output dev_sdio_o, dev_sdio_oe, serial_data_output);
  modport host (output sclk, cs_n, resync, io_update, host_sdio_o,
                host_sdio_oe, input sdio, serial_data_output);
endinterface : dds_serial_if
`default_nettype wire

// [rtl/dds_core.sv]
// Synthesis core with serial port, buffered controls and clock mode
`default_nettype none
module dds_core (
  input wire logic clock,
  input wire logic rst,
  dds_serial_if.device link,
  input wire logic oscillator_select_pin,
  output logic [dds_pkg::ACC_W-1:0] phase_word,
  output logic [dds_pkg::DAC_W-1:0] dac_sample,
  output logic [dds_pkg::MULT_W-1:0] pll_multiplier,
  output logic pll_enable,
  output logic clock_stopped,
  output logic oscillator_enable,
  output logic crystal_out_enable,
  output logic [dds_pkg::MULT_W-1:0] clock_ratio
);
  import dds_pkg::*;

  logic sclk_q;
  logic rise;
  logic fall;
  logic abort;
  logic [5:0] cnt_reg;
  logic [7:0] instr_reg;
  logic [31:0] data_reg;
  logic [31:0] data_next;
  logic [31:0] rd_word_reg;
  logic frame_done_reg;
  logic [5:0] width;
  logic [5:0] pos;
  logic [4:0] addr;
  logic is_read;
  logic [31:0] pend_one_reg;
  logic [31:0] pend_two_reg;
  logic [31:0] pend_ftw_reg;
  logic [31:0] ctrl_one_reg;
  logic [31:0] ctrl_two_reg;
  logic [31:0] ftw_reg;
  logic [ACC_W-1:0] acc_reg;
  logic lsb_first;
  logic three_wire;
  logic [MULT_W-1:0] mult;
  logic mult_ok;

  ////////////////////////////////////////////////////////////////////
  // Serial port framing
  assign lsb_first = ctrl_one_reg[LSB_FIRST_POS];
  assign three_wire = ctrl_one_reg[THREE_WIRE_POS];
  assign rise = link.sclk & ~sclk_q;
  assign fall = ~link.sclk & sclk_q;
  assign abort = link.cs_n | link.resync;
  assign addr = instr_reg[4:0];
  assign is_read = instr_reg[READ_FLAG_POS];
  assign width = reg_bits(addr);
  assign pos = frame_pos(cnt_reg, width, lsb_first);

  always_ff @(posedge clock) begin
    if (rst) begin
      sclk_q <= 1'b0;
    end else begin
      sclk_q <= link.sclk;
    end
  end

  always_comb begin
    data_next = data_reg;
    data_next[pos[4:0]] = link.sdio;
  end

  always_ff @(posedge clock) begin
    if (rst || abort) begin
      cnt_reg <= 6'h00;
      instr_reg <= 8'h00;
      data_reg <= 32'h0000_0000;
      frame_done_reg <= 1'b0;
    end else if (rise && !frame_done_reg) begin
      if (cnt_reg < 6'h08) begin
        instr_reg[pos[2:0]] <= link.sdio;
      end else begin
        data_reg <= data_next;
      end
      if (cnt_reg >= 6'h08 && cnt_reg == width + 6'h07) begin
        frame_done_reg <= 1'b1;
      end
      cnt_reg <= cnt_reg + 6'h01;
    end
  end

  // Read word captured when instruction completes
  always_ff @(posedge clock) begin
    if (rst) begin
      rd_word_reg <= 32'h0000_0000;
    end else if (rise && cnt_reg == 6'h07) begin
      // Last instruction bit is still on the wire in msb-first order
      case (lsb_first ? instr_reg[4:0] : {instr_reg[4:1], link.sdio})
        ADDR_CTRL_ONE: rd_word_reg <= pend_one_reg;
        ADDR_CTRL_TWO: rd_word_reg <= pend_two_reg;
        ADDR_FTW: rd_word_reg <= pend_ftw_reg;
        default: rd_word_reg <= 32'h0000_0000;
      endcase
    end
  end

  // Drive read bits; output pin only in three-wire
  always_ff @(posedge clock) begin
    if (rst || abort) begin
      link.dev_sdio_o <= 1'b0;
      link.dev_sdio_oe <= 1'b0;
      link.serial_data_output <= 1'b0;
    end else if (fall && is_read && cnt_reg >= 6'h08
                 && !frame_done_reg) begin
      link.dev_sdio_o <= rd_word_reg[pos[4:0]];
      link.dev_sdio_oe <= ~three_wire;
      link.serial_data_output <= three_wire & rd_word_reg[pos[4:0]];
    end else if (frame_done_reg) begin
      link.dev_sdio_oe <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Pending and active control registers
  // Writes land in pending copies
  always_ff @(posedge clock) begin
    if (rst) begin
      pend_one_reg <= PEND_ONE_RESET;
      pend_two_reg <= CTRL_TWO_RESET;
      pend_ftw_reg <= FTW_RESET;
    end else if (rise && !abort && !frame_done_reg && !is_read
                 && cnt_reg >= 6'h08 && cnt_reg == width + 6'h07) begin
      case (addr)
        ADDR_CTRL_ONE: pend_one_reg <= data_next;
        ADDR_CTRL_TWO: pend_two_reg <= {8'h00, data_next[23:0]};
        ADDR_FTW: pend_ftw_reg <= data_next;
        default: pend_ftw_reg <= pend_ftw_reg;
      endcase
    end
  end

  // Active clear set, pending clear at reset
  always_ff @(posedge clock) begin
    if (rst) begin
      ctrl_one_reg <= CTRL_ONE_RESET;
      ctrl_two_reg <= CTRL_TWO_RESET;
      ftw_reg <= FTW_RESET;
    end else if (link.io_update) begin
      ctrl_one_reg <= pend_one_reg;
      ctrl_two_reg <= pend_two_reg;
      ftw_reg <= pend_ftw_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Phase accumulator and cosine mapper
  // Accumulate tuning word; zero word holds
  always_ff @(posedge clock) begin
    if (rst) begin
      acc_reg <= '0;
    end else if (ctrl_one_reg[CLEAR_POS]) begin
      acc_reg <= '0;
    end else begin
      acc_reg <= acc_reg + ftw_reg;
    end
  end

  // Quarter-wave amplitude table
  function automatic logic [8:0] quarter(input logic [3:0] i);
    case (i)
      4'h0: quarter = 9'd511;
      4'h1: quarter = 9'd509;
      4'h2: quarter = 9'd501;
      4'h3: quarter = 9'd489;
      4'h4: quarter = 9'd472;
      4'h5: quarter = 9'd451;
      4'h6: quarter = 9'd425;
      4'h7: quarter = 9'd395;
      4'h8: quarter = 9'd361;
      4'h9: quarter = 9'd324;
      4'ha: quarter = 9'd284;
      4'hb: quarter = 9'd241;
      4'hc: quarter = 9'd196;
      4'hd: quarter = 9'd148;
      4'he: quarter = 9'd100;
      default: quarter = 9'd50;
    endcase
  endfunction : quarter

  // Offset-binary cosine of the top phase bits
  function automatic logic [DAC_W-1:0] cosine_mapper(
      input logic [ACC_W-1:0] ph);
    logic [1:0] q;
    logic [3:0] i;
    q = ph[ACC_W-1 -: 2];
    i = ph[ACC_W-3 -: 4];
    case (q)
      2'h0: cosine_mapper = 10'h200 + {1'b0, quarter(i)};
      2'h1: cosine_mapper = 10'h200 - {1'b0, quarter(4'hf - i)};
      2'h2: cosine_mapper = 10'h200 - {1'b0, quarter(i)};
      default: cosine_mapper = 10'h200 + {1'b0, quarter(4'hf - i)};
    endcase
  endfunction : cosine_mapper

  // Clear bit zeroes phase; ten-bit samples
  always_ff @(posedge clock) begin
    if (rst) begin
      phase_word <= '0;
      dac_sample <= '0;
    end else begin
      phase_word <= ctrl_one_reg[CLEAR_POS] ? '0 : acc_reg;
      dac_sample <= cosine_mapper(
          ctrl_one_reg[CLEAR_POS] ? '0 : acc_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Clock mode selection
  // Multiplier field bits seven to three
  assign mult = ctrl_two_reg[MULT_LSB +: MULT_W];
  assign mult_ok = (mult >= MULT_MIN) && (mult <= MULT_MAX);

  always_ff @(posedge clock) begin
    if (rst) begin
      pll_multiplier <= '0;
      pll_enable <= 1'b0;
      clock_stopped <= 1'b0;
      oscillator_enable <= 1'b0;
      crystal_out_enable <= 1'b0;
      clock_ratio <= '0;
    end else begin
      pll_multiplier <= mult;
      pll_enable <= mult_ok;
      clock_stopped <= ctrl_one_reg[GATE_POS];
      oscillator_enable <= oscillator_select_pin;
      crystal_out_enable <= oscillator_select_pin
                            & ctrl_two_reg[XTAL_OUT_POS];
      if (ctrl_one_reg[GATE_POS]) begin
        clock_ratio <= '0;
      end else begin
        clock_ratio <= mult_ok ? mult : 5'h01;
      end
    end
  end
endmodule : dds_core
`default_nettype wire

// [rtl/dds_host.sv]
// Host controller driving the synthesis core serial port
`default_nettype none
module dds_host #(
  parameter int LOCK_CYCLES = dds_pkg::PLL_LOCK_CYCLES,
  parameter int HALF = dds_pkg::SCLK_HALF_CYCLES
) (
  input wire logic clock,
  input wire logic rst,
  dds_serial_if.host link,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata
);
  import dds_pkg::*;

  if (HALF < 2 || HALF > 255 || LOCK_CYCLES < 1) begin : g_param_check
    $error("dds_host: unsupported HALF or LOCK_CYCLES");
  end

  typedef enum {IDLE, LOW, HIGH, STROBE, LOCK} host_e;
  host_e state_reg;
  logic cfg_lsb_reg;
  logic cfg_three_reg;
  logic [4:0] cmd_addr_reg;
  logic cmd_read_reg;
  logic cmd_upd_reg;
  logic [31:0] wdata_reg;
  logic [31:0] rx_reg;
  logic [5:0] cnt_reg;
  logic [7:0] div_reg;
  logic [31:0] lock_reg;
  logic [5:0] width;
  logic [5:0] pos;
  logic [7:0] instr;
  logic tx_bit;
  logic rx_bit;
  logic start;

  assign width = reg_bits(cmd_addr_reg);
  assign pos = frame_pos(cnt_reg, width, cfg_lsb_reg);
  assign instr = {cmd_read_reg, 2'b00, cmd_addr_reg};
  assign tx_bit = (cnt_reg < 6'h08) ? instr[pos[2:0]]
                                    : wdata_reg[pos[4:0]];
  // Read data on output pin in three-wire
  assign rx_bit = cfg_three_reg ? link.serial_data_output : link.sdio;
  assign start = wr && addr == HOST_CMD && state_reg == IDLE;

  ////////////////////////////////////////////////////////////////////
  // Software registers
  always_ff @(posedge clock) begin
    if (rst) begin
      cfg_lsb_reg <= 1'b0;
      cfg_three_reg <= 1'b0;
      wdata_reg <= 32'h0000_0000;
      cmd_addr_reg <= 5'h00;
      cmd_read_reg <= 1'b0;
      cmd_upd_reg <= 1'b0;
    end else if (wr && state_reg == IDLE) begin
      case (addr)
        HOST_CONFIG: begin
          cfg_lsb_reg <= wdata[CFG_LSB_POS];
          cfg_three_reg <= wdata[CFG_THREE_POS];
        end
        HOST_WDATA: wdata_reg <= wdata;
        HOST_CMD: begin
          cmd_addr_reg <= wdata[4:0];
          cmd_read_reg <= wdata[CMD_READ_POS];
          cmd_upd_reg <= wdata[CMD_UPDATE_POS];
        end
        default: cmd_upd_reg <= cmd_upd_reg;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      rdata <= 32'h0000_0000;
    end else if (rd) begin
      case (addr)
        HOST_WDATA: rdata <= wdata_reg;
        HOST_RDATA: rdata <= rx_reg;
        HOST_STATUS: rdata <= {30'h0, state_reg == LOCK,
                               state_reg != IDLE};
        HOST_CONFIG: rdata <= {30'h0, cfg_three_reg, cfg_lsb_reg};
        HOST_CMD: rdata <= {23'h0, cmd_upd_reg, cmd_read_reg,
                            2'b00, cmd_addr_reg};
        default: rdata <= 32'h0000_0000;
      endcase
    end else begin
      rdata <= 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Serial frame sequencer
  // Select low, bits in chosen order
  always_ff @(posedge clock) begin
    if (rst) begin
      state_reg <= IDLE;
      cnt_reg <= 6'h00;
      div_reg <= 8'h00;
      lock_reg <= 32'h0;
      rx_reg <= 32'h0;
      link.sclk <= 1'b0;
      link.cs_n <= 1'b1;
      link.resync <= 1'b0;
      link.io_update <= 1'b0;
      link.host_sdio_o <= 1'b0;
      link.host_sdio_oe <= 1'b0;
    end else begin
      link.io_update <= 1'b0;
      case (state_reg)
        IDLE: begin
          if (start) begin
            state_reg <= LOW;
            cnt_reg <= 6'h00;
            div_reg <= 8'h00;
            link.cs_n <= 1'b0;
          end
        end
        LOW: begin
          link.host_sdio_o <= tx_bit;
          link.host_sdio_oe <= cfg_three_reg || !cmd_read_reg
                               || cnt_reg < 6'h08;
          div_reg <= div_reg + 8'h01;
          if (div_reg == 8'(HALF - 1)) begin
            div_reg <= 8'h00;
            link.sclk <= 1'b1;
            state_reg <= HIGH;
          end
        end
        HIGH: begin
          div_reg <= div_reg + 8'h01;
          if (div_reg == 8'(HALF - 1)) begin
            div_reg <= 8'h00;
            link.sclk <= 1'b0;
            if (cmd_read_reg && cnt_reg >= 6'h08) begin
              rx_reg[pos[4:0]] <= rx_bit;
            end
            if (cnt_reg == width + 6'h07) begin
              link.cs_n <= 1'b1;
              link.host_sdio_oe <= 1'b0;
              state_reg <= cmd_upd_reg ? STROBE : IDLE;
            end else begin
              cnt_reg <= cnt_reg + 6'h01;
              state_reg <= LOW;
            end
          end
        end
        STROBE: begin
          link.io_update <= 1'b1;
          lock_reg <= 32'h0;
          state_reg <= (cmd_addr_reg == ADDR_CTRL_TWO && !cmd_read_reg)
                       ? LOCK : IDLE;
        end
        LOCK: begin
          lock_reg <= lock_reg + 32'h1;
          if (lock_reg == 32'(LOCK_CYCLES - 1)) begin
            state_reg <= IDLE;
          end
        end
        default: state_reg <= IDLE;
      endcase
    end
  end
endmodule : dds_host
`default_nettype wire

// [sim/dds_link_monitor.sv]
// Concurrent checks on the serial link and clock indicators
`default_nettype none
module dds_link_monitor (
  input wire logic clock,
  input wire logic rst,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic io_update,
  input wire logic host_sdio_oe,
  input wire logic dev_sdio_oe,
  input wire logic oscillator_select_pin,
  input wire logic [dds_pkg::MULT_W-1:0] pll_multiplier,
  input wire logic pll_enable,
  input wire logic clock_stopped,
  input wire logic oscillator_enable,
  input wire logic crystal_out_enable,
  input wire logic [dds_pkg::MULT_W-1:0] clock_ratio
);
  import dds_pkg::*;
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////
  sequence desel_s;
    $rose(cs_n) ##1 cs_n;
  endsequence
  sequence sclk_up_s;
    $rose(sclk);
  endsequence
  ////////////////////////////////////////////////////////////
  osc_follow_a: assert property (
    !$past(rst) |-> oscillator_enable == $past(oscillator_select_pin))
    else $error("oscillator enable not following select pin");
  xtal_osc_a: assert property (
    crystal_out_enable |-> oscillator_enable)
    else $error("crystal output on without oscillator");
  pll_range_a: assert property (
    pll_enable == (pll_multiplier >= MULT_MIN && pll_multiplier <= MULT_MAX))
    else $error("pll enable wrong for multiplier");
  stop_zero_a: assert property (
    clock_stopped |-> clock_ratio == 5'h00)
    else $error("stopped clock with nonzero ratio");
  ratio_mult_a: assert property (
    pll_enable && !clock_stopped |-> clock_ratio == pll_multiplier)
    else $error("ratio differs from multiplier");
  ratio_bypass_a: assert property (
    !$past(rst) && !clock_stopped && !pll_enable |-> clock_ratio == 5'h01)
    else $error("bypass ratio not one");
  upd_pulse_a: assert property (
    io_update |=> !io_update)
    else $error("update strobe longer than one cycle");
  upd_desel_a: assert property (
    io_update |-> cs_n)
    else $error("update strobe inside a frame");
  drive_one_a: assert property (
    !(host_sdio_oe && dev_sdio_oe))
    else $error("both ends drive the data wire");
  desel_quiet_a: assert property (
    desel_s |-> !dev_sdio_oe)
    else $error("core drives data wire while deselected");
  sclk_sel_a: assert property (
    sclk_up_s |-> !cs_n ##1 sclk)
    else $error("serial clock pulse bad or unselected");
endmodule : dds_link_monitor
`default_nettype wire

// [sim/dds_core_clock_config_tb_top.sv]
// Testbench joining the serial host and the synthesis core
`default_nettype none
module dds_core_clock_config_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import dds_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic oscillator_select_pin = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic [31:0] phase_word;
  logic [9:0] dac_sample;
  logic [4:0] pll_multiplier;
  logic [4:0] clock_ratio;
  logic pll_enable;
  logic clock_stopped;
  logic oscillator_enable;
  logic crystal_out_enable;
  int err_count = 0;
  int checks = 0;
  logic [39:0] frame_bits = 40'h0;
  int frame_cnt = 0;
  int dev_cnt = 0;
  int sdo_cnt = 0;
  logic sclk_d = 1'b0;
  logic cs_d = 1'b1;
  dds_serial_if link ();
  dds_core i_dds_core (.clock(clock), .rst(rst), .link(link),
    .oscillator_select_pin(oscillator_select_pin), .phase_word(phase_word),
    .dac_sample(dac_sample), .pll_multiplier(pll_multiplier),
    .pll_enable(pll_enable), .clock_stopped(clock_stopped),
    .oscillator_enable(oscillator_enable),
    .crystal_out_enable(crystal_out_enable), .clock_ratio(clock_ratio));
  dds_host #(.LOCK_CYCLES(8), .HALF(2)) i_dds_host (.clock(clock),
    .rst(rst), .link(link), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata));
  dds_link_monitor i_dds_link_monitor (.clock(clock), .rst(rst),
    .sclk(link.sclk), .cs_n(link.cs_n), .io_update(link.io_update),
    .host_sdio_oe(link.host_sdio_oe), .dev_sdio_oe(link.dev_sdio_oe),
    .oscillator_select_pin(oscillator_select_pin),
    .pll_multiplier(pll_multiplier), .pll_enable(pll_enable),
    .clock_stopped(clock_stopped), .oscillator_enable(oscillator_enable),
    .crystal_out_enable(crystal_out_enable), .clock_ratio(clock_ratio));
  ////////////////////////////////////////////////////////////
  initial begin
    forever #10 clock = ~clock;
  end
  // Wire capture of each frame
  always @(posedge clock) begin
    sclk_d <= link.sclk;
    cs_d <= link.cs_n;
    if (!link.cs_n && cs_d) begin
      frame_cnt <= 0;
    end else if (!link.cs_n && link.sclk && !sclk_d) begin
      frame_bits <= {frame_bits[38:0], link.sdio};
      frame_cnt <= frame_cnt + 1;
    end
    if (link.dev_sdio_oe) dev_cnt <= dev_cnt + 1;
    if (link.serial_data_output) sdo_cnt <= sdo_cnt + 1;
  end
  ////////////////////////////////////////////////////////////
  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic give_verdict();
    $display("checks=%0d err_count=%0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : give_verdict
  function automatic logic [4:0] ratio_of(input logic [4:0] m,
      input logic g);
    if (g) ratio_of = 5'h00;
    else if (m >= 5'h04 && m <= 5'h14) ratio_of = m;
    else ratio_of = 5'h01;
  endfunction : ratio_of
  function automatic logic [39:0] wire_frame(input logic [7:0] ins,
      input logic [31:0] d, input logic lsb);
    wire_frame = {ins, d};
    if (lsb) for (int k = 0; k < 8; k++) wire_frame[32+k] = ins[7-k];
    if (lsb) for (int k = 0; k < 32; k++) wire_frame[k] = d[31-k];
  endfunction : wire_frame
  task automatic host_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask : host_wr
  task automatic host_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : host_rd
  task automatic link_op(input logic upd, input logic rf,
      input logic [4:0] a, input logic [31:0] d);
    logic [31:0] s;
    int n;
    n = 0;
    host_wr(HOST_WDATA, d);
    host_wr(HOST_CMD, {23'h0, upd, rf, 2'h0, a});
    do begin
      host_rd(HOST_STATUS, s);
      n++;
    end while (s[0] !== 1'b0 && n < 400);
    if (n >= 400) check(s, 40'h0);
    repeat (4) @(posedge clock);
    #1;
  endtask : link_op
  task automatic link_rd(input logic [4:0] a, output logic [31:0] d);
    link_op(1'b0, 1'b1, a, 32'h0);
    host_rd(HOST_RDATA, d);
  endtask : link_rd
  task automatic step(output logic [31:0] diff);
    logic [31:0] p0;
    @(posedge clock);
    #1 p0 = phase_word;
    @(posedge clock);
    #1 diff = phase_word - p0;
  endtask : step
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (60000) @(posedge clock);
    err_count++;
    give_verdict();
  end
  initial begin
    logic [31:0] v;
    logic [31:0] f;
    logic [4:0] mm;
    logic xo;
    logic gate;
    logic pin;
    int dc;
    int sc;
    void'($urandom(73));
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    repeat (20) @(posedge clock);
    #1;
    check(phase_word, 40'h0);
    check({pll_multiplier, pll_enable, clock_stopped}, 40'h0);
    check(clock_ratio, 40'h01);
    link_rd(ADDR_CTRL_ONE, v);
    check(v, 40'h0);
    f = $urandom | 32'h1;
    link_op(1'b0, 1'b0, ADDR_FTW, f);
    check(frame_cnt, 40'd40);
    check(frame_bits, wire_frame(8'h04, f, 1'b0));
    check(phase_word, 40'h0);
    link_rd(ADDR_FTW, v);
    check(v, f);
    check(frame_bits, wire_frame(8'h84, f, 1'b0));
    check({dev_cnt > 0, sdo_cnt == 0}, 40'h3);
    link_op(1'b1, 1'b0, ADDR_CTRL_ONE, 32'h0);
    for (int i = 0; i < 4; i++) begin
      f = (i == 1) ? 32'hffffffff : (i == 2) ? 32'h80000000 : $urandom;
      link_op(1'b1, 1'b0, ADDR_FTW, f);
      step(v);
      check(v, f);
    end
    link_op(1'b1, 1'b0, ADDR_FTW, 32'h0);
    step(v);
    check(v, 40'h0);
    link_op(1'b1, 1'b0, ADDR_CTRL_ONE, 32'h400);
    link_op(1'b1, 1'b0, ADDR_FTW, 32'h80000000);
    step(v);
    check(v, 40'h0);
    check(phase_word, 40'h0);
    link_op(1'b1, 1'b0, ADDR_CTRL_ONE, 32'h0);
    for (int i = 0; i < 2; i++) begin
      step(v);
      check(phase_word[30:0], 40'h0);
      check(dac_sample >= 10'h3c0, !phase_word[31]);
      check(dac_sample <= 10'h040, phase_word[31]);
    end
    for (int m = 0; m < 32; m++) begin
      mm = 5'(m);
      xo = 1'($urandom);
      gate = 1'($urandom);
      pin = 1'($urandom);
      @(posedge clock);
      oscillator_select_pin <= pin;
      link_op(1'b1, 1'b0, ADDR_CTRL_TWO, {22'h0, xo, 1'b0, mm, 3'h0});
      link_op(1'b1, 1'b0, ADDR_CTRL_ONE, {27'h0, gate, 4'h0});
      check(pll_multiplier, mm);
      check(pll_enable, mm >= 5'h04 && mm <= 5'h14);
      check(clock_ratio, ratio_of(mm, gate));
      check(clock_stopped, gate);
      check({oscillator_enable, crystal_out_enable}, {pin, pin & xo});
    end
    link_op(1'b1, 1'b0, ADDR_CTRL_ONE, 32'h100);
    host_wr(HOST_CONFIG, 32'h1);
    f = $urandom | 32'h1;
    link_op(1'b0, 1'b0, ADDR_FTW, f);
    check(frame_bits, wire_frame(8'h04, f, 1'b1));
    link_op(1'b1, 1'b0, ADDR_CTRL_ONE, 32'h300);
    host_wr(HOST_CONFIG, 32'h3);
    dc = dev_cnt;
    sc = sdo_cnt;
    link_rd(ADDR_FTW, v);
    check(v, f);
    link_rd(ADDR_CTRL_ONE, v);
    check(v, 40'h300);
    check({dev_cnt == dc, sdo_cnt > sc}, 40'h3);
    link_op(1'b1, 1'b0, ADDR_CTRL_TWO, 32'ha0);
    check(pll_multiplier, 40'h14);
    @(posedge clock);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    repeat (3) @(posedge clock);
    #1;
    check({pll_multiplier, clock_stopped, clock_ratio}, 40'h01);
    check(phase_word, 40'h0);
    link_rd(ADDR_CTRL_TWO, v);
    check(v, 40'h0);
    give_verdict();
  end
endmodule : dds_core_clock_config_tb_top
`default_nettype wire
